// *** mwp_chk_if.sv ***
`timescale 1ns/1ps
// Purpose: carries a protection query between top and range checker
// Assumes: all signals on one clock
// Notes: purely combinational relation
interface mwp_chk_if #(parameter int AW = 24);
    logic [AW-1:0] addr;
    logic [2:0] level;
    logic top_bottom;
    logic [AW-1:0] top_addr;
    logic hit;
    modport req (output addr, output level, output top_bottom, output top_addr, input hit);
    modport chk (input addr, input level, input top_bottom, input top_addr, output hit);
endinterface

// *** mwp_host_model.sv ***
`timescale 1ns/1ps
// Purpose: host side issuing decoder-level write requests
// Assumes: requests launched just after a rising edge
// Notes: released address and data go inverted, not held
module mwp_host_model
    import mwp_pkg::*;
(
    // clock
    input wire logic clk,
    // requests
    output logic latch_set,
    output logic latch_clr,
    output mwp_kind_t kind,
    output logic [ADDR_W-1:0] addr,
    output logic [7:0] data
);
    initial
    begin
        latch_set = 1'b0;
        latch_clr = 1'b0;
        kind = MWP_W_IDLE;
        addr = '0;
        data = '0;
    end
    task automatic write_latch(input logic clr);
        @(posedge clk);
        latch_set <= ~clr;
        latch_clr <= clr;
        @(posedge clk);
        latch_set <= 1'b0;
        latch_clr <= 1'b0;
    endtask
    task automatic wr(input mwp_kind_t k, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        kind <= k;
        addr <= a;
        data <= d;
        @(posedge clk);
        kind <= MWP_W_IDLE;
        addr <= ~a;
        data <= ~d;
        #1;
    endtask
endmodule

// *** mwp_pkg.sv ***
// Purpose: constants and types for the write protection unit
// Assumes: one 8-bit status image, one 8-bit section mask
// Notes: bit positions and reset values named here; status writes also use literal bit slices
package mwp_pkg;
    localparam int SR_HPE_BIT = 7;
    localparam int SR_SNL_BIT = 6;
    localparam int SR_TB_BIT = 5;
    localparam int SR_BP_LSB = 2;
    localparam int SR_WL_BIT = 1;
    localparam logic [7:0] SR_NV_MASK = 8'hfc;
    localparam logic [7:0] SR_RESET = 8'h20;
    localparam logic [7:0] ASP_RESET = 8'h00;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_ALL = 3'h7;
    localparam int AUX_SECT_LSB = 5;
    localparam int ADDR_W = 24;

    // write kinds presented by the command decoder
    typedef enum logic [5:0] {
        MWP_W_IDLE = 6'h01,
        MWP_W_STATUS = 6'h02,
        MWP_W_CONFIG = 6'h04,
        MWP_W_SERIAL = 6'h08,
        MWP_W_ASP = 6'h10,
        MWP_W_ARRAY = 6'h20
    } mwp_kind_t;
endpackage

// *** mwp_protect.sv ***
`timescale 1ns/1ps
// Purpose: write protection decisions for a serial nonvolatile memory
// Assumes: decoder gives one-cycle write strobes after a command completes
// Notes: nonvolatile image loaded from NV_* while NV_LOAD is high
// Function
// - pin low plus enable blocks registers
// - pin high or enable clear unblocks
// - write latch set by command, cleared powerup
// - latch clear blocks everything
// - latch read-only in status
// - block range always refused when latched
// - status bits seven to two nonvolatile
// - serial lock blocks serial writes
// - top/bottom picks protected end
// - level code selects protected fraction
// - ranges follow array density
// - range bits need pin/enable and unlocked
// - each mask bit maps to 32 bytes but guards no write
// - mask nonvolatile, readable, resets zero
// - array lock freezes range bits
// - aux lock only freezes the mask
module mwp_protect
    import mwp_pkg::*;
#(
    parameter logic [ADDR_W-1:0] TOP_ADDR = 24'h1fffff
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // pin and locks
    input wire logic WP_N,
    input wire logic ARRAY_PROT_LOCK,
    input wire logic AUX_AREA_LOCK,
    // nonvolatile image
    input wire logic NV_LOAD,
    input wire logic [7:0] NV_STATUS,
    input wire logic [7:0] NV_AUX_MASK,
    // decoder
    input wire logic WRITE_LATCH_SET,
    input wire logic WRITE_LATCH_CLR,
    input wire mwp_kind_t WR_KIND,
    input wire logic [ADDR_W-1:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    // results
    output logic [7:0] PROTECTION_STATUS,
    output logic [7:0] AUX_PROTECT_MASK,
    output logic WR_ACCEPT,
    output logic WR_REJECT
);
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] mask;
        logic accept;
        logic reject;
    } mwp_state_t;

    mwp_state_t st;
    mwp_state_t next_st;
    logic hw_prot;
    logic reg_ok;
    logic aux_blk;
    logic ok;
    mwp_chk_if #(.AW(ADDR_W)) chk ();

    assign chk.addr = WR_ADDR;
    assign chk.level = st.status[SR_BP_LSB +: 3];
    assign chk.top_bottom = st.status[SR_TB_BIT];
    assign chk.top_addr = TOP_ADDR;

    mwp_range_chk u_rng (.q(chk));

    always_comb
    begin
        next_st = st;
        next_st.accept = 1'b0;
        next_st.reject = 1'b0;
        hw_prot = st.status[SR_HPE_BIT] && !WP_N;
        reg_ok = st.status[SR_WL_BIT] && !hw_prot;
        aux_blk = AUX_AREA_LOCK || st.mask[WR_ADDR[AUX_SECT_LSB +: 3]];
        ok = 1'b0;
        // refusal only drops the store; the serial transfer still ends normally
        case (WR_KIND)
            MWP_W_STATUS: ok = reg_ok;
            MWP_W_CONFIG: ok = reg_ok;
            MWP_W_SERIAL: ok = reg_ok && !st.status[SR_SNL_BIT];
            MWP_W_ASP: ok = reg_ok;
            MWP_W_ARRAY: ok = st.status[SR_WL_BIT] && !chk.hit;
            default: ok = 1'b0;
        endcase
        if (WR_KIND != MWP_W_IDLE)
        begin
            next_st.accept = ok;
            next_st.reject = !ok;
        end
        if (ok && WR_KIND == MWP_W_STATUS)
        begin
            // latch bit and reserved bit not writable
            next_st.status[7:6] = WR_DATA[7:6];
            if (!ARRAY_PROT_LOCK)
            begin
                next_st.status[5:2] = WR_DATA[5:2];
            end
        end
        // aux lock also freezes the mask
        if (ok && WR_KIND == MWP_W_ASP && !AUX_AREA_LOCK)
        begin
            next_st.mask = WR_DATA;
        end
        if (WRITE_LATCH_SET)
        begin
            next_st.status[SR_WL_BIT] = 1'b1;
        end
        else if (WRITE_LATCH_CLR)
        begin
            next_st.status[SR_WL_BIT] = 1'b0;
        end
        if (NV_LOAD)
        begin
            // built on next_st so a same-cycle latch set is not lost
            next_st.status = (NV_STATUS & SR_NV_MASK) | (next_st.status & ~SR_NV_MASK);
            next_st.mask = NV_AUX_MASK;
        end
    end

    // constants only under reset; NV image arrives later on NV_LOAD
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            st <= '{status: SR_RESET, mask: ASP_RESET, accept: 1'b0, reject: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign PROTECTION_STATUS = st.status;
    assign AUX_PROTECT_MASK = st.mask;
    assign WR_ACCEPT = st.accept;
    assign WR_REJECT = st.reject;

    // properties look at the registered answer one edge after the request

    latch_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND != MWP_W_IDLE && !st.status[SR_WL_BIT] && !WRITE_LATCH_SET)
        |=> !WR_ACCEPT && WR_REJECT)
        else $error("write accepted with latch clear");
    hw_block_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_STATUS && st.status[SR_HPE_BIT] && !WP_N && !NV_LOAD)
        |=> $stable(PROTECTION_STATUS[7:2]) && WR_REJECT)
        else $error("status changed under hw protect");
    hw_release_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_STATUS && WP_N && st.status[SR_WL_BIT])
        |=> WR_ACCEPT)
        else $error("status write refused with pin high");
    latch_set_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        WRITE_LATCH_SET |=> PROTECTION_STATUS[SR_WL_BIT])
        else $error("latch not set");
    // set, a quiet cycle, then a status write
    sequence latch_armed_s;
        WRITE_LATCH_SET ##1 !WRITE_LATCH_CLR ##1 (WR_KIND == MWP_W_STATUS && WP_N);
    endsequence
    arm_then_write_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        latch_armed_s |=> WR_ACCEPT)
        else $error("armed status write refused");
    latch_ro_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (!WRITE_LATCH_SET && !WRITE_LATCH_CLR)
        |=> $stable(PROTECTION_STATUS[SR_WL_BIT]))
        else $error("latch changed by data");
    rsvd_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !PROTECTION_STATUS[0])
        else $error("reserved status bit set");
    range_refuse_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_ARRAY && chk.hit) |=> WR_REJECT)
        else $error("protected array write accepted");
    // outside the range accepted when latched
    range_accept_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_ARRAY && st.status[SR_WL_BIT] && !chk.hit) |=> WR_ACCEPT)
        else $error("unprotected array write refused");
    serial_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_SERIAL && st.status[SR_SNL_BIT]) |=> WR_REJECT)
        else $error("serial write accepted while locked");
    // unlocked range bits take the written value
    range_write_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_STATUS && st.status[SR_WL_BIT] && WP_N
            && !ARRAY_PROT_LOCK && !NV_LOAD)
        |=> (PROTECTION_STATUS & 8'h3c) == ($past(WR_DATA) & 8'h3c))
        else $error("range bits not written");
    range_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (ARRAY_PROT_LOCK && !NV_LOAD) |=> $stable(PROTECTION_STATUS[5:2]))
        else $error("range bits changed while locked");
    aux_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (AUX_AREA_LOCK && !NV_LOAD) |=> $stable(AUX_PROTECT_MASK))
        else $error("mask changed while aux locked");
    discard_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (WR_KIND == MWP_W_STATUS && !reg_ok && !NV_LOAD)
        |=> $stable(PROTECTION_STATUS[7:2]))
        else $error("refused status write stored");
    // never both answers at once
    one_answer_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !(WR_ACCEPT && WR_REJECT))
        else $error("accept and reject together");
endmodule

// *** mwp_range_chk.sv ***
`timescale 1ns/1ps
// Purpose: decides whether an array address lies in the block-protected range
// Assumes: top_addr is all ones below the density msb
// Notes: region size is (top_addr+1) >> (7-level) for levels 1 to 7; level 0 protects nothing
module mwp_range_chk
    import mwp_pkg::*;
(
    mwp_chk_if.chk q
);
    logic [ADDR_W-1:0] span;
    logic [ADDR_W-1:0] low_end;
    always_comb
    begin
        span = q.top_addr >> (3'h7 - q.level);
        low_end = q.top_addr - span;
        if (q.level == BP_NONE)
        begin
            q.hit = 1'b0;
        end
        else if (q.level == BP_ALL)
        begin
            q.hit = (q.addr <= q.top_addr);
        end
        else if (q.top_bottom)
        begin
            q.hit = (q.addr <= span);
        end
        else
        begin
            q.hit = (q.addr >= low_end) && (q.addr <= q.top_addr);
        end
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// Purpose: self-checking bench for the write protection unit
// Assumes: smallest density, top address 01ffff
// Notes: expected status tracked in st
module tb_top
    import mwp_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1, alock = 1'b0, xlock = 1'b0, nv_load = 1'b0;
    logic [7:0] nv_status = 8'h1e, nv_mask = 8'h81;
    logic set, clr, acc, rej;
    mwp_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data, status, mask, st;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int sz;
    always #4 clk = ~clk;
    mwp_host_model host_u (.clk(clk), .latch_set(set), .latch_clr(clr), .kind(kind),
        .addr(addr), .data(data));
    mwp_protect #(.TOP_ADDR(24'h01ffff)) dut_u (.CORE_CLK(clk), .RSTN(rstn), .WP_N(wp_n),
        .ARRAY_PROT_LOCK(alock), .AUX_AREA_LOCK(xlock), .NV_LOAD(nv_load),
        .NV_STATUS(nv_status), .NV_AUX_MASK(nv_mask), .WRITE_LATCH_SET(set),
        .WRITE_LATCH_CLR(clr), .WR_KIND(kind), .WR_ADDR(addr), .WR_DATA(data),
        .PROTECTION_STATUS(status), .AUX_PROTECT_MASK(mask), .WR_ACCEPT(acc),
        .WR_REJECT(rej));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_acc(input logic exp);
        cmp_count++;
        if ({acc, rej} !== {exp, ~exp})
        begin
            n_errors++;
            $display("ERROR %0t accept %b reject %b", $time, acc, rej);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // locked range bits keep their old value
    task automatic sw(input logic [7:0] d, input logic ok);
        host_u.write_latch(1'b0);
        host_u.wr(MWP_W_STATUS, '0, d);
        chk_acc(ok);
        if (ok)
            st = {d[7:6], alock ? st[5:2] : d[5:2], 2'b10};
        chk(status, st);
    endtask
    task automatic aw(input logic [ADDR_W-1:0] a, input logic ok);
        host_u.wr(MWP_W_ARRAY, a, 8'h00);
        chk_acc(ok);
    endtask
    // run is under two hundred cycles, ceiling well above
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            conclude();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        chk(status, SR_RESET);
        chk(mask, ASP_RESET);
        rstn <= 1'b1;
        @(posedge clk) nv_load <= 1'b1;
        @(posedge clk) nv_load <= 1'b0;
        #1;
        st = 8'h1c;
        chk(status, st);
        chk(mask, 8'h81);
        host_u.wr(MWP_W_STATUS, '0, 8'h00);
        chk_acc(1'b0);
        chk(status, st);
        host_u.write_latch(1'b0);
        #1 chk(status, 8'h1e);
        aw(24'h000000, 1'b0);
        for (int t = 0; t < 2; t++)
            for (int l = 1; l < 7; l++)
            begin
                sw({2'b00, t[0], l[2:0], 2'b00}, 1'b1);
                sz = 32'h20000 >> (7 - l);
                aw(ADDR_W'(t ? sz - 1 : 32'h20000 - sz), 1'b0);
                aw(ADDR_W'(t ? sz : 32'h1ffff - sz), 1'b1);
            end
        sw(8'h80, 1'b1);
        @(posedge clk) wp_n <= 1'b0;
        sw(8'h00, 1'b0);
        host_u.wr(MWP_W_CONFIG, '0, 8'h00);
        chk_acc(1'b0);
        aw(24'h01ffff, 1'b1);
        @(posedge clk) wp_n <= 1'b1;
        sw(8'h40, 1'b1);
        host_u.wr(MWP_W_SERIAL, '0, 8'h00);
        chk_acc(1'b0);
        sw(8'h00, 1'b1);
        host_u.wr(MWP_W_SERIAL, '0, 8'h00);
        chk_acc(1'b1);
        aw(24'h000000, 1'b1);
        @(posedge clk) alock <= 1'b1;
        sw(8'h7c, 1'b1);
        host_u.wr(MWP_W_ASP, '0, 8'h5a);
        chk_acc(1'b1);
        chk(mask, 8'h5a);
        @(posedge clk) xlock <= 1'b1;
        host_u.wr(MWP_W_ASP, '0, 8'h00);
        chk_acc(1'b1);
        chk(mask, 8'h5a);
        host_u.write_latch(1'b1);
        #1 chk(status, st & 8'hfd);
        aw(24'h000000, 1'b0);
        // power cycle: latch comes back clear, new image reloads
        host_u.write_latch(1'b0);
        @(posedge clk) rstn <= 1'b0;
        nv_status <= 8'hc3;
        nv_mask <= 8'h3c;
        @(posedge clk) rstn <= 1'b1;
        chk(status, SR_RESET);
        @(posedge clk) nv_load <= 1'b1;
        @(posedge clk) nv_load <= 1'b0;
        #1 chk(status, 8'hc0);
        chk(mask, 8'h3c);
        aw(24'h000000, 1'b0);
        conclude();
    end
endmodule
